// ==== spir_regs.sv ====
/*
 * Serial peripheral receive register slice: interrupt enable set/clear,
 * receive frame capture with select state and start flag, sticky event
 * status, and an Avalon-MM slave with waitrequest.
 * Assumes sck_i, sdi_i and sel_i come from pins outside the mclk_i domain
 * and that sck_i is much slower than mclk_i (at least 4 mclk per half period).
 */
// Added by the designer: the Avalon-MM slave port.
`timescale 1ns/10ps
module spir_regs
   import spir_pkg::*;
(
   input  wire logic                          mclk_i,
   input  wire logic                          reset_i,
   input  wire logic [spir_pkg::ADDR_W-1:0]   avs_address_i,
   input  wire logic                          avs_read_i,
   input  wire logic                          avs_write_i,
   input  wire logic [spir_pkg::DATA_W-1:0]   avs_writedata_i,
   output logic      [spir_pkg::DATA_W-1:0]   avs_readdata_o,
   output logic                               avs_waitrequest_o,
   input  wire logic                          sck_i,
   input  wire logic                          sdi_i,
   input  wire logic [spir_pkg::SEL_N-1:0]    sel_i,
   output logic                               irq_o
);
   import spir_pkg::*;

   ////////////////////////////////////////////////////////////////////////////
   // pin synchronisers
   logic [SYNC_W-1:0] pins_s;
   logic              sck_s;
   logic              sdi_s;
   logic [SEL_N-1:0]  sel_s;

   spir_sync #(.W(SYNC_W)) u_sync (
      .clk_i   (mclk_i),
      .reset_i (reset_i),
      .d_i     ({sck_i, sdi_i, sel_i}),
      .q_o     (pins_s)
   );

   assign sck_s = pins_s[SYNC_W-1];
   assign sdi_s = pins_s[SYNC_W-2];
   assign sel_s = pins_s[SEL_N-1:0];

   ////////////////////////////////////////////////////////////////////////////
   // registers
   logic                ack_r;
   logic [IRQ_N-1:0]    ien_r;
   logic [IRQ_N-1:0]    stat_r;
   logic [SEL_N-1:0]    pol_r;
   logic [LEN_W-1:0]    frame_length_r;
   logic [DATA_W-1:0]   rxf_r;
   logic [DATA_W-1:0]   rdata_r;
   logic [FRAME_W-1:0]  shift_r;
   logic [LEN_W-1:0]    bitcnt_r;
   logic                sck_d_r;
   logic                any_d_r;
   logic                sot_pend_r;

   ////////////////////////////////////////////////////////////////////////////
   // bus decode: one wait cycle, request taken when waitrequest is low
   logic go;
   logic go_wr;
   logic go_rd;
   logic hit_cfg;
   logic hit_stat;
   logic hit_set;
   logic hit_clr;
   logic hit_rxf;
   logic hit_txc;
   logic [IRQ_N-1:0] wd_irq;

   assign go       = (avs_read_i | avs_write_i) & ack_r;
   assign go_wr    = go & avs_write_i;
   assign go_rd    = go & avs_read_i;
   assign hit_cfg  = avs_address_i == CFG_ADDR;
   assign hit_stat = avs_address_i == STAT_ADDR;
   assign hit_set  = avs_address_i == IEN_SET_ADDR;
   assign hit_clr  = avs_address_i == IEN_CLR_ADDR;
   assign hit_rxf  = avs_address_i == RXF_ADDR;
   assign hit_txc  = avs_address_i == TXC_ADDR;
   assign wd_irq   = avs_writedata_i[IRQ_N-1:0];
   assign avs_waitrequest_o = (avs_read_i | avs_write_i) & ~ack_r;
   assign avs_readdata_o    = rdata_r;

   // unmapped and write-only addresses read as zero
   logic [DATA_W-1:0] rmux;
   assign rmux = hit_cfg  ? {28'h0000000, pol_r} :
                 hit_stat ? {26'h0000000, stat_r} :
                 hit_set  ? {26'h0000000, ien_r} :
                 hit_rxf  ? rxf_r :
                 hit_txc  ? {4'h0, frame_length_r, 24'h000000} :
                 32'h0000_0000;

   // read data is captured in the wait cycle and stands at the taking edge
   always_ff @(posedge mclk_i or posedge reset_i) begin
      if (reset_i) begin
         ack_r   <= 1'b0;
         rdata_r <= 32'h0000_0000;
      end else begin
         ack_r   <= (avs_read_i | avs_write_i) & ~ack_r;
         rdata_r <= rmux;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // select activity and its edges
   logic [SEL_N-1:0] sel_act;
   logic             any_act;
   logic             ev_assert;
   logic             ev_deassert;
   logic             sck_rise;

   assign sel_act     = ~(sel_s ^ pol_r);  // polarity bit 1 means active high
   assign any_act     = |sel_act;
   assign ev_assert   = any_act & ~any_d_r;
   assign ev_deassert = ~any_act & any_d_r;
   assign sck_rise    = sck_s & ~sck_d_r;

   ////////////////////////////////////////////////////////////////////////////
   // frame assembly
   logic                 shift_en;
   logic                 store;
   logic [FRAME_W-1:0]   shift_nxt;
   logic [FRAME_W:0]     len_one;
   logic [FRAME_W-1:0]   len_mask;
   logic [DATA_W-1:0]    rxf_nxt;
   logic                 overrun;

   assign shift_en  = sck_rise & any_act;
   assign shift_nxt = {shift_r[FRAME_W-2:0], sdi_s};
   assign store     = shift_en & (bitcnt_r == frame_length_r);
   // ones in the low frame_length+1 positions
   assign len_one   = 17'h00001 << ({1'b0, frame_length_r} + 5'h01);
   assign len_mask  = 16'(len_one - 17'h00001);
   // data, active-low select state, start flag packed together; a frame that
   // lands in the very cycle a select goes active is still the first one
   assign rxf_nxt   = {11'h000, sot_pend_r | ev_assert, ~sel_act,
                       shift_nxt & len_mask};
   assign overrun   = store & stat_r[IRQ_RXRDY];

   // bit counter restarts whenever no select is active
   always_ff @(posedge mclk_i or posedge reset_i) begin
      if (reset_i) begin
         sck_d_r  <= 1'b0;
         any_d_r  <= 1'b0;
         shift_r  <= 16'h0000;
         bitcnt_r <= 4'h0;
      end else begin
         sck_d_r  <= sck_s;
         any_d_r  <= any_act;
         shift_r  <= shift_en ? shift_nxt : shift_r;
         bitcnt_r <= ~any_act ? 4'h0 : store ? 4'h0 : shift_en ? bitcnt_r + 4'h1 : bitcnt_r;
      end
   end

   // frame register has no reset: contents undefined until first frame
   always_ff @(posedge mclk_i) begin
      if (store) begin
         rxf_r <= rxf_nxt;  // bus writes never reach it
      end
   end

   // start flag pends from select assertion to the next frame stored in a later cycle
   always_ff @(posedge mclk_i or posedge reset_i) begin
      if (reset_i) begin
         sot_pend_r <= 1'b0;
      end else if (ev_assert) begin
         sot_pend_r <= 1'b1;
      end else if (store) begin
         sot_pend_r <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // configuration registers
   always_ff @(posedge mclk_i or posedge reset_i) begin
      if (reset_i) begin
         pol_r  <= POL_RST;
         frame_length_r <= FRAME_LENGTH_RST;
      end else begin
         pol_r  <= (go_wr & hit_cfg) ? avs_writedata_i[POL_LSB+:SEL_N] : pol_r;
         frame_length_r <= (go_wr & hit_txc) ? avs_writedata_i[FRAME_LENGTH_LSB+:LEN_W] : frame_length_r;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // interrupt enables: set register ors in, clear register masks out
   logic [IRQ_N-1:0] ien_nxt;
   assign ien_nxt = (go_wr & hit_set) ? (ien_r | wd_irq) :
                    (go_wr & hit_clr) ? (ien_r & ~wd_irq) :
                    ien_r;

   always_ff @(posedge mclk_i or posedge reset_i) begin
      if (reset_i) begin
         ien_r <= IEN_RST;
      end else begin
         ien_r <= ien_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // event status: rx ready is data-unread, others sticky write-one-clear
   logic [IRQ_N-1:0] ev_set;
   logic [IRQ_N-1:0] w1c;
   logic [IRQ_N-1:0] stat_nxt;
   logic             rd_frame;

   assign rd_frame = go_rd & hit_rxf;
   assign ev_set   = {ev_deassert, ev_assert, 1'b0, overrun, 1'b0, store};
   assign w1c      = (go_wr & hit_stat) ? wd_irq : 6'h00;
   // a new event in the clearing cycle survives: set wins
   assign stat_nxt = ev_set | (stat_r & ~w1c & ~{5'h00, rd_frame});

   always_ff @(posedge mclk_i or posedge reset_i) begin
      if (reset_i) begin
         stat_r <= STAT_RST;
      end else begin
         stat_r <= stat_nxt;
      end
   end

   // level interrupt while any enabled status bit stands
   assign irq_o = |(stat_r & ien_r);

   ////////////////////////////////////////////////////////////////////////////
   // assertions
   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (reset_i);

   // reference for the start flag: frames stored since the last select assertion,
   // saturating at 2 so a long transfer never wraps back to "first"
   logic [1:0] frm_cnt_r;

   always_ff @(posedge mclk_i or posedge reset_i) begin
      if (reset_i) begin
         frm_cnt_r <= 2'h2;
      end else if (ev_assert) begin
         frm_cnt_r <= {1'b0, store};
      end else if (store && frm_cnt_r != 2'h2) begin
         frm_cnt_r <= frm_cnt_r + 2'h1;
      end
   end

   clr_drops_en_a: assert property (
      go_wr && hit_clr |=> (ien_r & $past(wd_irq)) == 6'h00)
      else $error("enable not cleared by a one");

   clr_zero_keeps_a: assert property (
      go_wr && hit_clr |=> (ien_r & ~$past(wd_irq)) == ($past(ien_r) & ~$past(wd_irq)))
      else $error("enable changed by a zero");

   rx_read_only_a: assert property (
      go_wr && hit_rxf && !store |=> rxf_r == $past(rxf_r))
      else $error("receive frame changed by a write");

   len_mask_a: assert property (
      store |=> (rxf_r[FRAME_W-1:0] & ~$past(len_mask)) == 16'h0000)
      else $error("data beyond frame length");

   sel_capture_a: assert property (
      store |=> rxf_r[RXSEL_LSB+:SEL_N] == $past(~(sel_s ^ ~pol_r)))
      else $error("select state not captured");

   rx_irq_a: assert property (
      store && ien_r[IRQ_RXRDY] && !(go_wr && hit_clr) |=> irq_o)
      else $error("no interrupt for received data");

   ss_irq_a: assert property (
      ev_assert && ien_r[IRQ_SSA] && !(go_wr && hit_clr) |=> irq_o [*2])
      else $error("no interrupt for select assert");

   sot_flag_a: assert property (
      store && (frm_cnt_r == 2'h0 || ev_assert) |=> rxf_r[SOT_BIT])
      else $error("start flag missing");

   sot_clear_a: assert property (
      store && frm_cnt_r != 2'h0 && !ev_assert |=> !rxf_r[SOT_BIT])
      else $error("start flag on later frame");

   rx_ready_set_a: assert property (
      store |=> stat_r[IRQ_RXRDY])
      else $error("receive ready not flagged");

   rx_ready_clr_a: assert property (
      rd_frame && !store |=> !stat_r[IRQ_RXRDY])
      else $error("receive ready not cleared by read");

   ss_status_a: assert property (
      ev_assert |=> stat_r[IRQ_SSA])
      else $error("select assert not flagged");

   bus_wait_a: assert property (
      (avs_read_i || avs_write_i) && avs_waitrequest_o |=> !avs_waitrequest_o)
      else $error("bus answer later than one wait cycle");
endmodule // spir_regs

// ==== spir_pkg.sv ====
/*
 * Shared constants for the serial receive register slice: register byte
 * addresses, field positions, reset values and widths.
 * Assumes a 32-bit Avalon-MM slave port with byte addresses.
 */
package spir_pkg;
   // widths
   localparam int unsigned ADDR_W   = 32;
   localparam int unsigned DATA_W   = 32;
   localparam int unsigned SEL_N    = 4;
   localparam int unsigned FRAME_W  = 16;
   localparam int unsigned LEN_W    = 4;
   localparam int unsigned IRQ_N    = 6;
   localparam int unsigned SYNC_W   = SEL_N + 2;

   ////////////////////////////////////////////////////////////////////////////
   // register byte addresses
   localparam logic [31:0] CFG_ADDR     = 32'h4005_8000;
   localparam logic [31:0] STAT_ADDR    = 32'h4005_8008;
   localparam logic [31:0] IEN_SET_ADDR = 32'h4005_800c;
   localparam logic [31:0] IEN_CLR_ADDR = 32'h4005_8010;
   localparam logic [31:0] RXF_ADDR     = 32'h4005_8014;
   localparam logic [31:0] TXC_ADDR     = 32'h4005_8020;

   ////////////////////////////////////////////////////////////////////////////
   // field positions
   localparam int unsigned POL_LSB     = 0;   // cfg: select_polarity [3:0]
   localparam int unsigned FRAME_LENGTH_LSB    = 24;  // tx_control: frame_length [27:24]
   localparam int unsigned RXSEL_LSB   = 16;  // receive_frame: rx_select_state [19:16]
   localparam int unsigned SOT_BIT     = 20;  // receive_frame: transfer_start_flag
   localparam int unsigned IRQ_RXRDY   = 0;
   localparam int unsigned IRQ_TXRDY   = 1;
   localparam int unsigned IRQ_RXOV    = 2;
   localparam int unsigned IRQ_TXUR    = 3;
   localparam int unsigned IRQ_SSA     = 4;
   localparam int unsigned IRQ_SSD     = 5;

   ////////////////////////////////////////////////////////////////////////////
   // reset values
   localparam logic [IRQ_N-1:0] IEN_RST  = 6'h00;
   localparam logic [IRQ_N-1:0] STAT_RST = 6'h00;
   localparam logic [SEL_N-1:0] POL_RST  = 4'h0;
   localparam logic [LEN_W-1:0] FRAME_LENGTH_RST = 4'h7;
endpackage : spir_pkg

// ==== spir_sync.sv ====
/*
 * Two-flop level synchroniser, one lane per bit.
 * Assumes inputs are asynchronous to clk_i; the first stage feeds only the
 * second stage.
 */
`timescale 1ns/10ps
module spir_sync #(
   parameter int unsigned W = 1
) (
   input  wire logic         clk_i,
   input  wire logic         reset_i,
   input  wire logic [W-1:0] d_i,
   output logic      [W-1:0] q_o
);
   logic [W-1:0] meta_r;

   // first stage is read by the second stage only
   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         meta_r <= '0;
         q_o    <= '0;
      end else begin
         meta_r <= d_i;
         q_o    <= meta_r;
      end
   end
endmodule // spir_sync

// ==== spir_link_model.sv ====
/* behavioural serial master that drives the receive slice's link pins.
   assumes the bench calls its tasks; sck idles low outside frames. */
`timescale 1ns/10ps
module spir_link_model
   import spir_pkg::*;
(
   output logic             sck_o,
   output logic             sdi_o,
   output logic [SEL_N-1:0] sel_o
);
   logic [SEL_N-1:0] pol_r;
   // idle state: clock still, every select inactive
   initial begin
      sck_o = 1'b0;
      sdi_o = 1'b0;
      pol_r = 4'h0;
      sel_o = 4'hf;
   end
   // park all selects at the inactive level of a new polarity
   // every task first steps 3 ns off the bench clock edges to avoid races
   task automatic set_pol(input logic [SEL_N-1:0] pol);
      #3;
      pol_r = pol;
      sel_o = ~pol;
      #100;
   endtask
   // one select active, the rest stay inactive
   task automatic open_sel(input int idx);
      #3;
      sel_o[idx] = pol_r[idx];
      #200;
   endtask
   // msb first, data moves on the falling edge, 160 ns per bit
   task automatic shift(input logic [15:0] d, input int n);
      #3;
      for (int i = n - 1; i >= 0; i--) begin
         sdi_o = d[i];
         #80 sck_o = 1'b1;
         #80 sck_o = 1'b0;
      end
   endtask
   // released data line shows the inverse so a stale bit never passes
   task automatic close_sel();
      #3;
      #100 sel_o = ~pol_r;
      sdi_o = ~sdi_o;
      #200;
   endtask
endmodule // spir_link_model

// ==== spir_regs_tb.sv ====
/* self-checking bench for spir_regs: enable set/clear, receive frame,
   interrupt. assumes spir_link_model as the far side of the link. */
`timescale 1ns/10ps
module spir_regs_tb;
   import spir_pkg::*;
   logic        mclk_i;
   logic        reset_i;
   logic [31:0] addr;
   logic        rd;
   logic        wr;
   logic [31:0] wdata;
   logic [31:0] rdata;
   logic        waitreq;
   logic        sck;
   logic        sdi;
   logic [3:0]  sel;
   logic        irq;
   logic [31:0] q;
   logic [15:0] lfsr;
   logic [15:0] d;
   logic [5:0]  pat;
   logic [3:0]  fl;
   int          idx;
   int          n_errors;
   int          total_checks;

   spir_regs i_dut (.mclk_i(mclk_i), .reset_i(reset_i), .avs_address_i(addr),
      .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wdata),
      .avs_readdata_o(rdata), .avs_waitrequest_o(waitreq), .sck_i(sck),
      .sdi_i(sdi), .sel_i(sel), .irq_o(irq));
   spir_link_model i_mst (.sck_o(sck), .sdi_o(sdi), .sel_o(sel));

   ////////////////////////////////////////////////////////////////////////////
   // 100 MHz clock
   initial begin
      mclk_i = 1'b0;
      forever #5 mclk_i = ~mclk_i;
   end

   function automatic logic [15:0] nxt(input logic [15:0] x);
      return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
   endfunction
   // expected word: data masked to n bits, chosen select reads 0
   function automatic logic [31:0] exp_rx(input logic [15:0] v, input int n,
                                          input int k, input logic transfer_start_flag);
      logic [3:0] s;
      s = 4'hf;
      s[k] = 1'b0;
      return {11'h000, transfer_start_flag, s, v & ((16'h0001 << n) - 16'h0001)};
   endfunction

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         n_errors++;
         $display("BAD %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   // one avalon transfer, held until waitrequest is sampled low
   task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] v);
      @(posedge mclk_i);
      rd <= ~w;
      wr <= w;
      addr <= a;
      wdata <= v;
      // wait for the answer as long as it takes; only the watchdog ends a hang
      do begin
         @(posedge mclk_i);
      end while (waitreq !== 1'b0);
      q = rdata;
      rd <= 1'b0;
      wr <= 1'b0;
   endtask
   task automatic give_verdict();
      $display("checks %0d errors %0d", total_checks, n_errors);
      if (n_errors == 0 && total_checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////////
   // watchdog: the whole run needs about 20 us, so 200 us means a hang
   initial begin
      #200000;
      n_errors++;
      $display("BAD %0t watchdog expired", $time);
      give_verdict();
   end

   // main sequence
   initial begin
      n_errors = 0;
      total_checks = 0;
      lfsr = 16'hfa01; // seed 64001
      reset_i = 1'b1;
      {rd, wr, addr, wdata} = '0;
      repeat (4) @(posedge mclk_i);
      reset_i <= 1'b0;
      bus(0, IEN_SET_ADDR, 0);
      check(q & 32'h3f, 32'h0);
      bus(0, 32'h4005_8004, 0);
      check(q, 32'h0);
      bus(1, STAT_ADDR, 32'h34);
      // single bits, then random patterns; upper bits always written zero
      for (int i = 0; i < 12; i++) begin
         lfsr = nxt(lfsr);
         pat = (i < 6) ? 6'h01 << i : lfsr[5:0];
         bus(1, IEN_SET_ADDR, 32'h3f);
         bus(1, IEN_CLR_ADDR, {26'h0, pat});
         bus(0, IEN_SET_ADDR, 0);
         check(q & 32'h3f, {26'h0, ~pat});
      end
      // frames with random polarity, select and length, corners first
      for (int i = 0; i < 6; i++) begin
         lfsr = nxt(lfsr);
         idx = lfsr[1:0];
         fl = (i == 0) ? 4'hf : (i == 1) ? 4'h0 : lfsr[9:6];
         i_mst.set_pol(lfsr[5:2]);
         bus(1, CFG_ADDR, {28'h0, lfsr[5:2]});
         bus(1, TXC_ADDR, {4'h0, fl, 24'h0});
         bus(1, IEN_CLR_ADDR, 32'h3f);
         bus(1, IEN_SET_ADDR, 32'h01);
         i_mst.open_sel(idx);
         d = nxt(lfsr);
         i_mst.shift(d, fl + 1);
         repeat (2) @(posedge mclk_i);
         check(irq, 1'b1);
         bus(0, RXF_ADDR, 0);
         check(q, exp_rx(d, fl + 1, idx, 1'b1));
         // a bus write must not disturb the read-only frame
         bus(1, RXF_ADDR, ~q);
         bus(0, RXF_ADDR, 0);
         check(q, exp_rx(d, fl + 1, idx, 1'b1));
         @(posedge mclk_i);
         check(irq, 1'b0);
         d = nxt(d);
         i_mst.shift(d, fl + 1);
         bus(0, RXF_ADDR, 0);
         check(q, exp_rx(d, fl + 1, idx, 1'b0));
         i_mst.close_sel();
      end
      // select-assert interrupt: raise, clear status, then mask
      bus(1, IEN_CLR_ADDR, 32'h3f);
      bus(1, STAT_ADDR, 32'h34);
      bus(1, IEN_SET_ADDR, 32'h10);
      @(posedge mclk_i);
      check(irq, 1'b0);
      i_mst.open_sel(2);
      check(irq, 1'b1);
      bus(1, STAT_ADDR, 32'h10);
      @(posedge mclk_i);
      check(irq, 1'b0);
      i_mst.close_sel();
      i_mst.open_sel(1);
      check(irq, 1'b1);
      bus(1, IEN_CLR_ADDR, 32'h10);
      @(posedge mclk_i);
      check(irq, 1'b0);
      i_mst.close_sel();
      give_verdict();
   end
endmodule // spir_regs_tb
